//--- bench/host_model.sv
// Host terminal model: sends queued command bytes, accepts replies
`timescale 1ns/1ps
module host_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       stall,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            tx_ready
);
  logic [7:0] q[$];
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
  endtask
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end
  // Byte held until taken; released data line shows inverse
  always @(posedge hclk) begin
    tx_ready <= !stall;
    if (hresetn && (!rx_valid || rx_ready)) begin
      if (q.size() != 0) begin
        rx_valid <= 1'b1;
        rx_data  <= q.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
      end
    end
  end
endmodule

//--- bench/tb_cmd_interp.sv
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
module tb_cmd_interp;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [31:0] seed = 32'h0000_E783;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic rx_valid, rx_err, rx_ready, tx_valid, tx_ready, stall;
  logic [7:0] rx_data, tx_data;
  logic cmd_valid, cmd_ready, res_valid, async_abort, abort, comm_err;
  logic reply_style_switch, autoexec_pin;
  cmd_pkg::cmd_t cmd;
  cmd_pkg::res_t res;
  logic [7:0]  exp_q[$];
  logic [47:0] ecmd_q[$];
  int fail_count, cmp_count, abort_n, pend, cyc;
  assign hready = hreadyout;
  cmd_interp i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_err(rx_err), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .res_valid(res_valid), .res(res), .async_abort(async_abort),
    .abort(abort), .comm_err(comm_err),
    .reply_style_switch(reply_style_switch), .autoexec_pin(autoexec_pin));
  host_model i_host (.hclk(hclk), .hresetn(hresetn), .stall(stall),
    .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic expect_line(input string s);
    string t;
    t = {"01:", s, "\015\012"};
    for (int i = 0; i < t.len(); i++) exp_q.push_back(t[i]);
  endtask
  task automatic expect_echo(input string s);
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
  endtask
  task automatic drain;
    while (exp_q.size() != 0) @(posedge hclk);
    repeat (40) @(posedge hclk);
  endtask
  // Reply bytes against the oldest noted byte
  always @(posedge hclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      check(tx_data, exp_q.size() ? exp_q.pop_front() : 9'h100);
    if (abort === 1'b1) abort_n++;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      summarize();
    end
  end
  // Engine model with random stalls
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t  = s ^ (s << 13);
    t  = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  always @(posedge hclk) begin
    seed = xs(seed);
    cmd_ready <= seed[0];
    stall     <= seed[1] & seed[2];
    res_valid <= (pend == 1);
    if (pend != 0) pend <= pend - 1;
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      check(cmd, ecmd_q.size() ? ecmd_q.pop_front() : 48'h0);
      res  <= '{err: 1'b0, has_val: cmd.letters == 16'h4D41,
                value: 32'h0000_1234};
      pend <= 3;
    end
  end
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, rx_err, async_abort} = 5'h00;
    {haddr, hwdata, htrans, hsize} = 69'h0;
    {reply_style_switch, autoexec_pin} = 2'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, cmd_pkg::ADDR_CTRL, 32'h0);
    check(rdv, 32'h0000_0100);
    ahb(1'b1, cmd_pkg::ADDR_CTRL, 32'h0000_0101);
    i_host.send("1 q l\015");
    expect_line("0");
    i_host.send("1pl5\015");
    expect_line("! DENIED");
    i_host.send("1PI0\0151PL5\0151QL\015");
    expect_line("OK");
    expect_line("OK");
    expect_line("full (5)");
    i_host.send("1BD\015");
    ecmd_q.push_back(48'h4244_0000_0000);
    expect_line("OK");
    i_host.send("1ma-12\015");
    ecmd_q.push_back(48'h4D41_FFFF_FFF4);
    expect_line("00001234");
    i_host.send("1PI7\0151IA\0152QL\0151QL\015");
    expect_line("! DENIED");
    expect_line("! DENIED");
    expect_line("5");
    drain();
    ahb(1'b0, cmd_pkg::ADDR_TIER, 32'h0);
    check(rdv, 32'h0000_0005);
    i_host.send("1ma3\0331ma4\003");
    drain();
    check(abort_n, 2);
    rx_err <= 1'b1;
    @(posedge hclk);
    rx_err <= 1'b0;
    repeat (4) @(posedge hclk);
    check(comm_err, 1'b1);
    check(abort_n, 3);
    ahb(1'b0, cmd_pkg::ADDR_STAT, 32'h0);
    check(rdv[1], 1'b1);
    ahb(1'b1, cmd_pkg::ADDR_STAT, 32'h0000_0002);
    ahb(1'b0, cmd_pkg::ADDR_STAT, 32'h0);
    check(rdv[1], 1'b0);
    async_abort <= 1'b1;
    @(posedge hclk);
    async_abort <= 1'b0;
    drain();
    check(ecmd_q.size(), 0);
    hresetn <= 1'b0;
    reply_style_switch <= 1'b1;
    autoexec_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    expect_line("Ready");
    expect_line("Autoexecuting sequence 0");
    @(posedge hclk);
    ahb(1'b1, cmd_pkg::ADDR_CTRL, 32'h0000_0100);
    drain();
    i_host.send("1QL\015");
    expect_echo("1QL\015");
    expect_line("Level = 0");
    drain();
    async_abort <= 1'b1;
    @(posedge hclk);
    async_abort <= 1'b0;
    expect_line("! ABORT");
    drain();
    summarize();
  end
endmodule

//--- logic/cmd_interp.sv
// ASCII command line interpreter with replies and access tiers
//
// Notes on behaviour
// R01: No echo on the multi-drop interface
// R02: Style switch picks quiet or verbose
// R03: Verbose adds label; quiet sends bare value
// R04: Quiet answers everything except escape, control-C
// R05: Unsolicited messages only in verbose style
// R06: Verbose start-up messages, autoexec notice
// R07: Host sends address, letters, value, CR
// R08: Either letter case; spaces dropped
// R09: Escape, control-C immediate; rest in order
// R10: Waiting commands held, 256 characters maximum
// R11: Escape byte anywhere is the escape command
// R12: Reply OK or text, ended CR LF
// R13: Reply starts with address and colon
// R14: Error reply has bang fourth
// R15: Each command has a tier
// R16: Tier change only after security code; bus writes to ADDR_TIER change it without one
// R17: Ten tiers, zero to nine
// R18: Valid code opens every command
// R19: Tier query reports full and tier
// R20: Wrong code or power loss revokes
// R21: Host saves tier to flash
// R22: Point-to-point interface echoes received bytes
// R23: Framing error aborts, status shows it
// R24: Command above tier rejected with error
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module cmd_interp (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_data,
  input  wire logic          rx_err,
  output logic               rx_ready,
  output logic               tx_valid,
  output logic [7:0]         tx_data,
  input  wire logic          tx_ready,
  output logic               cmd_valid,
  output cmd_pkg::cmd_t      cmd,
  input  wire logic          cmd_ready,
  input  wire logic          res_valid,
  input  wire cmd_pkg::res_t res,
  input  wire logic          async_abort,
  output logic               abort,
  output logic               comm_err,
  input  wire logic          reply_style_switch,
  input  wire logic          autoexec_pin
);
  typedef enum {P_IDLE, P_RUN, P_REPLY} pst_t;

  function automatic logic [3:0] cmd_tier(input logic [15:0] c);
    if (c == cmd_pkg::C_TSET || c == cmd_pkg::C_NCODE) cmd_tier = 4'h9;
    else if (c == cmd_pkg::C_CODE) cmd_tier = 4'h0;
    else if (c == cmd_pkg::C_SAVE) cmd_tier = 4'h4;
    else begin
      case (c[15:8])
        "Q", "H": cmd_tier = 4'h0;
        "M", "W": cmd_tier = 4'h1;
        "X":      cmd_tier = 4'h2;
        "A", "P": cmd_tier = 4'h3;
        "J":      cmd_tier = 4'h4;
        "D":      cmd_tier = 4'h5;
        "K":      cmd_tier = 4'h7;
        "I", "C": cmd_tier = 4'h8;
        default:  cmd_tier = 4'h6;
      endcase
    end
  endfunction

  function automatic logic [63:0] hex8(input logic [31:0] v);
    logic [3:0] n;
    hex8 = '0;
    for (int i = 0; i < 8; i++) begin
      n = v[4*i +: 4];
      hex8[8*i +: 8] = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    end
  endfunction

  // Style switch and autoexec strap come from pins
  logic       sty_m_r, sty_r, aux_m_r, aux_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sty_m_r <= 1'b0;
      sty_r   <= 1'b0;
      aux_m_r <= 1'b0;
      aux_r   <= 1'b0;
    end else begin
      sty_m_r <= reply_style_switch;
      sty_r   <= sty_m_r; // R02
      aux_m_r <= autoexec_pin;
      aux_r   <= aux_m_r;
    end
  end
  wire logic verbose = sty_r;

  // Bus slave: one wait state, data phase answered from flops
  logic        ph_r, ph_wr_r, rs485_r, full_r, cerr_r;
  logic [7:0]  ph_addr_r, axis_r;
  logic [3:0]  tier_r;
  logic [31:0] code_r, rdata;
  logic        tset_wr, ncode_wr, code_ok, code_bad;
  logic [31:0] val_s;
  logic [8:0]  cnt_r;
  pst_t        pst_r;
  wire logic   wr = ph_r & ph_wr_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r      <= 1'b0;
      ph_wr_r   <= 1'b0;
      ph_addr_r <= 8'h00;
    end else begin
      ph_r      <= hsel & htrans[1] & hready;
      ph_wr_r   <= hwrite;
      ph_addr_r <= haddr[7:0];
    end
  end
  assign hreadyout = ~ph_r;
  assign hresp     = 1'b0;

  always_comb begin
    if (ph_addr_r == cmd_pkg::ADDR_CTRL)
      rdata = {16'h0000, axis_r, 7'h00, rs485_r};
    else if (ph_addr_r == cmd_pkg::ADDR_STAT)
      rdata = {15'h0000, cnt_r, 4'h0, verbose, pst_r != P_IDLE,
               cerr_r, full_r};
    else if (ph_addr_r == cmd_pkg::ADDR_TIER)
      rdata = {28'h000_0000, tier_r};
    else
      rdata = 32'h0000_0000;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (ph_r & ~ph_wr_r) hrdata <= rdata;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs485_r <= 1'b0;
      axis_r  <= cmd_pkg::AXIS_RST;
    end else if (wr && ph_addr_r == cmd_pkg::ADDR_CTRL) begin
      rs485_r <= hwdata[cmd_pkg::CTRL_RS485];
      axis_r  <= hwdata[cmd_pkg::CTRL_AXIS +: 8];
    end
  end
  // Tier and security code: software or the command stream
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tier_r <= cmd_pkg::TIER_RST;
      code_r <= cmd_pkg::CODE_RST;
    end else begin
      if (tset_wr) tier_r <= val_s[3:0]; // R16
      else if (wr && ph_addr_r == cmd_pkg::ADDR_TIER &&
               hwdata[3:0] <= cmd_pkg::TIER_MAX)
        tier_r <= hwdata[3:0];
      if (ncode_wr) code_r <= val_s;
      else if (wr && ph_addr_r == cmd_pkg::ADDR_CODE) code_r <= hwdata;
    end
  end
  // Full access lives until a wrong code or reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) full_r <= 1'b0; // R20
    else if (code_ok) full_r <= 1'b1; // R18
    else if (code_bad) full_r <= 1'b0; // R20
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cerr_r <= 1'b0;
    else if (rx_err) cerr_r <= 1'b1; // R23
    else if (wr && ph_addr_r == cmd_pkg::ADDR_STAT &&
             hwdata[cmd_pkg::STAT_CERR]) cerr_r <= 1'b0;
  end
  assign comm_err = cerr_r;

  // Receive side: echo, immediate commands, line buffer
  logic       echo_r;
  logic [7:0] echo_b_r;
  logic [7:0] mem_r [cmd_pkg::BUF_DEPTH];
  logic [cmd_pkg::BUF_AW-1:0] wp_r, rp_r;
  wire logic rx_acc = rx_valid & rx_ready;
  wire logic spec = rx_data == cmd_pkg::CH_ESC || rx_data == cmd_pkg::CH_CTLC;
  wire logic flush = (rx_acc & spec) | rx_err;
  wire logic pop = pst_r == P_IDLE && cnt_r != 9'h000;
  assign rx_ready = ~echo_r & (cnt_r != 9'(cmd_pkg::BUF_DEPTH)); // R10

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) abort <= 1'b0;
    else abort <= flush; // R09 R11 R23
  end
  always_ff @(posedge hclk) begin
    if (rx_acc & ~spec) mem_r[wp_r] <= rx_data;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= 9'h000;
    end else if (flush) begin
      rp_r  <= wp_r; // R09
      cnt_r <= 9'h000;
    end else begin
      if (rx_acc) wp_r <= wp_r + 1'b1; // R11
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + {8'h00, rx_acc} - {8'h00, pop};
    end
  end

  // Line parser
  logic [7:0]  f_addr_r, c1_r, c2_r;
  logic [1:0]  nl_r;
  logic [31:0] f_val_r;
  logic        f_neg_r;
  wire logic [7:0] pb = mem_r[rp_r];
  wire logic is_low = pb >= "a" && pb <= "z";
  wire logic [7:0] ub = is_low ? (pb & 8'hDF) : pb; // R08
  wire logic is_let = ub >= "A" && ub <= "Z";
  wire logic is_dig = pb >= "0" && pb <= "9";
  wire logic [7:0] dg = pb - cmd_pkg::CH_ZERO;
  wire logic [15:0] code16 = {c1_r, c2_r};
  wire logic dec = pop && pb == cmd_pkg::CH_CR && f_addr_r == axis_r;
  wire logic allowed = full_r | (cmd_tier(code16) <= tier_r); // R15 R17 R18
  wire logic is_code  = code16 == cmd_pkg::C_CODE;
  wire logic is_tset  = code16 == cmd_pkg::C_TSET;
  wire logic is_ncode = code16 == cmd_pkg::C_NCODE;
  wire logic is_tqry  = code16 == cmd_pkg::C_TQRY;
  wire logic tset_ok = full_r && val_s <= 32'(cmd_pkg::TIER_MAX);
  wire logic go_exec = dec & allowed &
                       ~(is_code | is_tset | is_ncode | is_tqry);
  assign val_s    = f_neg_r ? 32'h0 - f_val_r : f_val_r;
  assign code_ok  = dec & is_code & (val_s == code_r);
  assign code_bad = dec & is_code & (val_s != code_r);
  assign tset_wr  = dec & is_tset & allowed & tset_ok; // R16
  assign ncode_wr = dec & is_ncode & allowed;
  cmd_pkg::kind_t dec_kind;
  always_comb begin
    if (is_code) dec_kind = code_ok ? cmd_pkg::K_OK : cmd_pkg::K_ERR;
    else if (!allowed) dec_kind = cmd_pkg::K_ERR; // R24
    else if (is_tset) dec_kind = tset_ok ? cmd_pkg::K_OK : cmd_pkg::K_ERR;
    else if (is_tqry) dec_kind = cmd_pkg::K_TIER; // R19
    else dec_kind = cmd_pkg::K_OK;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_addr_r <= 8'h00;
      c1_r     <= 8'h00;
      c2_r     <= 8'h00;
      nl_r     <= 2'h0;
      f_val_r  <= 32'h0000_0000;
      f_neg_r  <= 1'b0;
    end else if (flush || (pop && pb == cmd_pkg::CH_CR)) begin
      f_addr_r <= 8'h00;
      c1_r     <= 8'h00;
      c2_r     <= 8'h00;
      nl_r     <= 2'h0;
      f_val_r  <= 32'h0000_0000;
      f_neg_r  <= 1'b0;
    end else if (pop && ub != cmd_pkg::CH_SP) begin // R08
      if (is_let && nl_r != 2'h2) begin
        if (nl_r == 2'h0) c1_r <= ub;
        else c2_r <= ub;
        nl_r <= nl_r + 2'h1;
      end else if (is_dig && nl_r == 2'h0) begin
        f_addr_r <= {f_addr_r[4:0], 3'h0} + {f_addr_r[6:0], 1'b0} + dg;
      end else if (is_dig) begin
        f_val_r <= {f_val_r[28:0], 3'h0} + {f_val_r[30:0], 1'b0} +
                   {24'h00_0000, dg};
      end else if (pb == cmd_pkg::CH_MINUS) begin
        f_neg_r <= 1'b1;
      end
    end
  end

  // Command sequencing: one line at a time, in order
  cmd_pkg::kind_t rep_kind_r;
  logic [31:0]    rep_val_r;
  logic           tk_rep;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pst_r      <= P_IDLE;
      rep_kind_r <= cmd_pkg::K_OK;
      rep_val_r  <= 32'h0000_0000;
      cmd_valid  <= 1'b0;
      cmd        <= '0;
    end else if (flush) begin
      pst_r     <= P_IDLE; // R09
      cmd_valid <= 1'b0;
    end else begin
      case (pst_r)
        P_IDLE: begin
          if (go_exec) begin
            cmd_valid <= 1'b1; // R09
            cmd       <= '{letters: code16, value: val_s};
            pst_r     <= P_RUN;
          end else if (dec) begin
            rep_kind_r <= dec_kind; // R04
            pst_r      <= P_REPLY;
          end
        end
        P_RUN: begin
          if (cmd_ready) cmd_valid <= 1'b0;
          if (res_valid && !cmd_valid) begin
            rep_val_r <= res.value;
            if (res.err) rep_kind_r <= cmd_pkg::K_ERR;
            else if (res.has_val) rep_kind_r <= cmd_pkg::K_VAL;
            else rep_kind_r <= cmd_pkg::K_OK;
            pst_r <= P_REPLY;
          end
        end
        P_REPLY: begin
          if (tk_rep) pst_r <= P_IDLE;
        end
        default: pst_r <= P_IDLE;
      endcase
    end
  end

  // Start-up and unsolicited messages
  logic [1:0] boot_r;
  logic       st_pend_r, au_pend_r, ab_pend_r, tk_st, tk_au, tk_ab;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) boot_r <= 2'h0;
    else if (boot_r != 2'h3) boot_r <= boot_r + 2'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_pend_r <= 1'b0;
      au_pend_r <= 1'b0;
      ab_pend_r <= 1'b0;
    end else begin
      if (boot_r == cmd_pkg::BOOT_FIRE) begin
        st_pend_r <= verbose; // R06
        au_pend_r <= verbose & aux_r; // R06
      end else begin
        if (tk_st) st_pend_r <= 1'b0;
        if (tk_au) au_pend_r <= 1'b0;
      end
      if (async_abort & verbose) ab_pend_r <= 1'b1; // R05
      else if (tk_ab | ~verbose) ab_pend_r <= 1'b0; // R05
    end
  end

  // Transmit: echo before any new reply (a reply under way finishes first), replies built byte by byte
  logic           busy_r;
  logic [4:0]     pos_r, blen, bi;
  cmd_pkg::kind_t kind_r;
  logic [255:0]   body;
  logic [7:0]     lbyte;
  wire logic [7:0]  tdig = cmd_pkg::CH_ZERO + {4'h0, tier_r};
  wire logic [63:0] hx = hex8(rep_val_r);
  wire logic load = ~tx_valid | tx_ready;
  wire logic can_go = ~busy_r & load & ~echo_r;
  assign tk_rep = can_go & (pst_r == P_REPLY);
  assign tk_st  = can_go & ~tk_rep & st_pend_r;
  assign tk_au  = can_go & ~tk_rep & ~st_pend_r & au_pend_r;
  assign tk_ab  = can_go & ~tk_rep & ~st_pend_r & ~au_pend_r & ab_pend_r;

  always_comb begin
    case (kind_r)
      cmd_pkg::K_ERR: begin // R14
        body = {cmd_pkg::S_DENY, 192'h0};
        blen = 5'd8;
      end
      cmd_pkg::K_VAL: begin // R03
        body = verbose ? {cmd_pkg::S_VLBL, hx, 128'h0} : {hx, 192'h0};
        blen = verbose ? 5'd16 : 5'd8;
      end
      cmd_pkg::K_TIER: begin // R19
        if (full_r && verbose)
          body = {cmd_pkg::S_TLBL, cmd_pkg::S_FULL, tdig, ")", 128'h0};
        else if (full_r)
          body = {cmd_pkg::S_FULL, tdig, ")", 192'h0};
        else if (verbose)
          body = {cmd_pkg::S_TLBL, tdig, 184'h0};
        else
          body = {tdig, 248'h0};
        blen = 5'(1 + (full_r ? 7 : 0) + (verbose ? 8 : 0));
      end
      cmd_pkg::K_START: begin
        body = {cmd_pkg::S_START, 216'h0};
        blen = 5'd5;
      end
      cmd_pkg::K_AUTO: begin
        body = {cmd_pkg::S_AUTO, 64'h0};
        blen = 5'd24;
      end
      cmd_pkg::K_ABORT: begin
        body = {cmd_pkg::S_ABORT, 200'h0};
        blen = 5'd7;
      end
      default: begin // R12
        body = {cmd_pkg::S_OK, 240'h0};
        blen = 5'd2;
      end
    endcase
    bi = pos_r - 5'd3;
    if (pos_r == 5'd0) lbyte = cmd_pkg::CH_ZERO + 8'(axis_r / 10); // R13
    else if (pos_r == 5'd1) lbyte = cmd_pkg::CH_ZERO + 8'(axis_r % 10);
    else if (pos_r == 5'd2) lbyte = cmd_pkg::CH_COLON; // R13
    else if (pos_r < blen + 5'd3) lbyte = body[8*(31 - bi) +: 8];
    else if (pos_r == blen + 5'd3) lbyte = cmd_pkg::CH_CR; // R12
    else lbyte = cmd_pkg::CH_LF; // R12
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      echo_r   <= 1'b0;
      echo_b_r <= 8'h00;
      busy_r   <= 1'b0;
      pos_r    <= 5'd0;
      kind_r   <= cmd_pkg::K_OK;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end else begin
      if (rx_acc & ~rs485_r) begin
        echo_r   <= 1'b1; // R22 R01
        echo_b_r <= rx_data;
      end
      if (load) tx_valid <= 1'b0;
      if (busy_r && load) begin
        tx_valid <= 1'b1;
        tx_data  <= lbyte;
        pos_r    <= pos_r + 5'd1;
        if (pos_r == blen + 5'd4) busy_r <= 1'b0;
      end else if (load && echo_r) begin
        tx_valid <= 1'b1; // R22
        tx_data  <= echo_b_r;
        echo_r   <= 1'b0;
      end else if (tk_rep | tk_st | tk_au | tk_ab) begin
        busy_r <= 1'b1;
        pos_r  <= 5'd0;
        if (tk_rep) kind_r <= rep_kind_r;
        else if (tk_st) kind_r <= cmd_pkg::K_START;
        else if (tk_au) kind_r <= cmd_pkg::K_AUTO;
        else kind_r <= cmd_pkg::K_ABORT;
      end
    end
  end

  no_echo_a: assert property ( // R01
    @(posedge hclk) disable iff (!hresetn)
    rx_acc && rs485_r && !echo_r |=> !echo_r)
    else $error("echo on multi-drop link");
  echo_a: assert property ( // R22
    @(posedge hclk) disable iff (!hresetn)
    rx_acc && !rs485_r |=> echo_r && echo_b_r == $past(rx_data))
    else $error("received byte not echoed");
  quiet_abort_a: assert property ( // R05
    @(posedge hclk) disable iff (!hresetn)
    !verbose |=> !ab_pend_r)
    else $error("unsolicited message queued in quiet style");
  esc_flush_a: assert property ( // R09
    @(posedge hclk) disable iff (!hresetn)
    rx_acc && spec |=> cnt_r == 9'h000 && abort && pst_r == P_IDLE)
    else $error("escape did not flush");
  buf_cap_a: assert property ( // R10
    @(posedge hclk) disable iff (!hresetn)
    cnt_r == 9'(cmd_pkg::BUF_DEPTH) |-> !rx_ready)
    else $error("buffer accepts past capacity");
  colon_pos_a: assert property ( // R13
    @(posedge hclk) disable iff (!hresetn)
    busy_r && load && pos_r == 5'd2 |=> tx_data == cmd_pkg::CH_COLON)
    else $error("colon not third");
  bang_pos_a: assert property ( // R14
    @(posedge hclk) disable iff (!hresetn)
    busy_r && load && pos_r == 5'd3 && kind_r == cmd_pkg::K_ERR
    |=> tx_data == cmd_pkg::CH_BANG)
    else $error("error reply lacks bang fourth");
  line_end_a: assert property ( // R12
    @(posedge hclk) disable iff (!hresetn)
    busy_r && load && pos_r == blen + 5'd4
    |=> tx_data == cmd_pkg::CH_LF && !busy_r)
    else $error("reply not ended by line feed");
  deny_tier_a: assert property ( // R24
    @(posedge hclk) disable iff (!hresetn)
    dec && !allowed && !is_code && !flush
    |=> !cmd_valid && rep_kind_r == cmd_pkg::K_ERR)
    else $error("command above tier not rejected");
  bad_code_a: assert property ( // R20
    @(posedge hclk) disable iff (!hresetn)
    code_bad |=> !full_r)
    else $error("wrong code kept full access");
  tier_guard_a: assert property ( // R16
    @(posedge hclk) disable iff (!hresetn)
    dec && is_tset && !full_r && !wr |=> tier_r == $past(tier_r))
    else $error("tier changed without code");
endmodule

//--- pkg/cmd_pkg.sv
// Constants, types and strings for the ASCII command interpreter
package cmd_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_TIER = 8'h08;
  localparam logic [7:0] ADDR_CODE = 8'h0C;
  localparam int         CTRL_RS485 = 0;
  localparam int         CTRL_AXIS  = 8;
  localparam int         STAT_CERR  = 1;
  localparam logic [7:0]  AXIS_RST = 8'h01;
  localparam logic [3:0]  TIER_RST = 4'h0;
  localparam logic [3:0]  TIER_MAX = 4'h9;
  localparam logic [31:0] CODE_RST = 32'h0000_0000;
  localparam int          BUF_DEPTH = 256;
  localparam int          BUF_AW    = 8;
  localparam logic [1:0]  BOOT_FIRE = 2'h2;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_ESC   = 8'h1B;
  localparam logic [7:0] CH_CTLC  = 8'h03;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_BANG  = 8'h21;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [15:0] C_CODE  = "PI";
  localparam logic [15:0] C_TSET  = "PL";
  localparam logic [15:0] C_NCODE = "NP";
  localparam logic [15:0] C_TQRY  = "QL";
  localparam logic [15:0] C_SAVE  = "BD";
  localparam logic [15:0]  S_OK    = "OK";
  localparam logic [63:0]  S_DENY  = "! DENIED";
  localparam logic [63:0]  S_VLBL  = "Value = ";
  localparam logic [63:0]  S_TLBL  = "Level = ";
  localparam logic [47:0]  S_FULL  = "full (";
  localparam logic [39:0]  S_START = "Ready";
  localparam logic [191:0] S_AUTO  = "Autoexecuting sequence 0";
  localparam logic [55:0]  S_ABORT = "! ABORT";
  typedef enum {K_OK, K_ERR, K_VAL, K_TIER, K_START, K_AUTO, K_ABORT} kind_t;
  typedef struct packed {
    logic [15:0] letters;
    logic [31:0] value;
  } cmd_t;
  typedef struct packed {
    logic        err;
    logic        has_val;
    logic [31:0] value;
  } res_t;
endpackage
